// [design/urxr_pkg.sv]
// Notes on behaviour
// - data read advances buffer to next frame
// - complete flag set while unread data exist
// - disable flushes buffer, aborts reception, clears flag
// - interrupt requested while flag set and enabled
// - error flags buffered, write-protected, no interrupt
// - frame error shows first stop bit
// - overrun when buffer full, shifter full, start
// - overrun cleared on successful buffer transfer
// - parity check only when upper mode bit
// - parity error stored per frame, zero when off
// - disabled receiver releases the pin
// - sixteen or eight samples per bit
// - falling edge starts detection, sample one
// - start voted on centre samples, reject noise
// - baud timing resynchronised on every start
// - sample states numbered per bit
// - bit value by three-sample majority
// - recover through first stop bit only
// - centre samples eight to ten or four to six
// - new start accepted right after stop vote
// - first stop bit moves frame to buffer
// - unused upper data bits read zero
package urxr_pkg;
   //----------------------------------------------------------
   // register map
   //----------------------------------------------------------
   localparam logic [3:0] URXR_ADDR_DATA   = 4'h0;   // serial_data_reg
   localparam logic [3:0] URXR_ADDR_STATUS = 4'h1;   // serial_status_reg
   localparam logic [3:0] URXR_ADDR_CTRL_B = 4'h2;   // serial_control_reg_b
   localparam logic [3:0] URXR_ADDR_CTRL_C = 4'h3;   // frame format
   // status bits
   localparam int URXR_ST_RXC  = 7;
   localparam int URXR_ST_FE   = 4;
   localparam int URXR_ST_DOR  = 3;
   localparam int URXR_ST_UPE  = 2;
   localparam int URXR_ST_U2X  = 1;
   // control b bits
   localparam int URXR_CB_RXCIE = 7;
   localparam int URXR_CB_RXEN  = 4;
   localparam int URXR_CB_SZ2   = 2;
   localparam int URXR_CB_RXB8  = 1;
   localparam int URXR_CB_TXB8  = 0;
   // control c bits
   localparam int URXR_CC_PMHI = 5;
   localparam int URXR_CC_PMLO = 4;
   localparam int URXR_CC_SBS  = 3;
   localparam int URXR_CC_SZHI = 2;
   localparam int URXR_CC_SZLO = 1;
   // reset values
   localparam logic [7:0] URXR_CTRL_B_RST = 8'h00;
   localparam logic [7:0] URXR_CTRL_C_RST = 8'h06;
   localparam logic [2:0] URXR_SZ_NINE    = 3'h7;
   // sampling
   localparam logic [3:0] URXR_SPB_NORM  = 4'hf;   // last state, 16 per bit
   localparam logic [3:0] URXR_SPB_DBL   = 4'h7;   // last state, 8 per bit
   localparam logic [3:0] URXR_VOTE_NORM = 4'h8;   // first voted sample
   localparam logic [3:0] URXR_VOTE_DBL  = 4'h4;
   localparam logic [3:0] URXR_CNT_ONE   = 4'h1;
   localparam logic [3:0] URXR_CNT_ZERO  = 4'h0;
   localparam logic [3:0] URXR_BIT_ZERO  = 4'h0;
   localparam int         URXR_DEPTH     = 2;
   // baud tick: 50 MHz / (16 * 115200) default, keeps frames short
   localparam int URXR_CLK_HZ  = 50000000;
   localparam int URXR_BAUD    = 115200;
   localparam int URXR_TICK_DIV = URXR_CLK_HZ / (16 * URXR_BAUD);
endpackage

// [design/urxr_vote.sv]
`timescale 1ns/10ps
// three-sample majority voter with sample-number window
module urxr_vote
   import urxr_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       reset,
   input  wire logic       clr,          // restart of a bit window
   input  wire logic       smp,          // sample strobe
   input  wire logic [3:0] num,          // sample number in bit
   input  wire logic [3:0] first,        // first voted sample
   input  wire logic       line,         // sampled line level
   output logic            bit_val       // majority so far
);
   logic [1:0] ones_r;                   // high samples seen in window
   logic       hit;                      // current sample is a high centre sample

   // the deciding sample is counted in the same cycle as the decision
   assign hit = smp && num >= first && num <= first + 4'h2 && line;

   //----------------------------------------------------------
   // counting of high centre samples
   //----------------------------------------------------------
   always_ff @(posedge clk) begin
      if (reset || clr) begin
         ones_r <= 2'b00;
      end else if (hit) begin
         ones_r <= ones_r + 2'b01;
      end
   end

   // two or three high gives one
   assign bit_val = ones_r[1] || (ones_r[0] && hit);
endmodule

// [design/urxr_top.sv]
`timescale 1ns/10ps
// receiver with avalon slave, oversampling, two-entry buffer
module urxr_top
   import urxr_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic [3:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [31:0] writedata,
   output logic      [31:0] readdata,
   output logic             waitrequest,
   input  wire logic        serial_rx_pin,
   output logic             rx_pin_override,
   output logic             rx_complete_irq
);
   //----------------------------------------------------------
   // declarations
   //----------------------------------------------------------
   typedef enum logic [1:0] {URXR_IDLE, URXR_START, URXR_DATA} urxr_state_t;
   urxr_state_t  state_r;                 // recovery state
   logic [7:0]   ctrl_b_r;                // control b
   logic [7:0]   ctrl_c_r;                // frame format
   logic         u2x_r;                   // double speed
   logic [15:0]  div_r;                   // tick divider
   logic         tick;                    // 16x baud tick
   logic         half_r;                  // halves tick in double mode
   logic         smp;                     // oversample strobe
   logic         line_r;                  // sampled line
   logic         prev_r;                  // previous sample
   logic [3:0]   cnt_r;                   // sample number minus one
   logic [3:0]   bit_r;                   // bit index in frame
   logic [8:0]   shf_r;                   // data shifter
   logic         par_r;                   // received parity bit
   logic         pchk_r;                  // parity check at frame
   logic         pend_r;                  // complete frame waits in shifter
   logic         pfe_r;                   // pending stop error
   logic         ppe_r;                   // pending parity error
   logic         dor_r;                   // overrun to store with next frame
   logic [11:0]  mem_r [URXR_DEPTH];      // buffer entries
   logic         wp_r;                    // write pointer
   logic         rp_r;                    // read pointer
   logic [1:0]   cnt_buf_r;               // entries held
   logic         vote;                    // majority result
   logic         vclr;                    // voter restart
   logic         rx_en;                   // receiver enable
   logic         ack_r;                   // one-cycle bus answer
   logic         rd_data;                 // data read taken
   logic [3:0]   last_s;                  // last sample state
   logic [3:0]   first_s;                 // first voted sample
   logic [3:0]   nbits;                   // data bits
   logic [2:0]   sz;                      // char_size_sel
   logic         pen;                     // parity_mode_hi
   logic         push;                    // frame into buffer
   logic         vote_end;                // last voted sample
   logic [11:0]  head;                    // entry at read pointer

   // data bits per size code
   function automatic logic [3:0] size_bits(input logic [2:0] code);
      case (code)
         3'h0:    size_bits = 4'h5;
         3'h1:    size_bits = 4'h6;
         3'h2:    size_bits = 4'h7;
         3'h7:    size_bits = 4'h9;
         default: size_bits = 4'h8;
      endcase
   endfunction

   assign sz       = {ctrl_b_r[URXR_CB_SZ2], ctrl_c_r[URXR_CC_SZHI], ctrl_c_r[URXR_CC_SZLO]};
   assign nbits    = size_bits(sz);
   assign pen      = ctrl_c_r[URXR_CC_PMHI];
   assign rx_en    = ctrl_b_r[URXR_CB_RXEN];
   assign last_s   = u2x_r ? URXR_SPB_DBL : URXR_SPB_NORM;
   assign first_s  = u2x_r ? URXR_VOTE_DBL : URXR_VOTE_NORM;
   assign vote_end = smp && (cnt_r + URXR_CNT_ONE) == first_s + 4'h2;
   assign head     = mem_r[rp_r];
   assign rx_pin_override = rx_en;

   //----------------------------------------------------------
   // oversample tick, 16x or 8x baud
   //----------------------------------------------------------
   always_ff @(posedge clk) begin
      if (reset || div_r == 16'(URXR_TICK_DIV - 1)) begin
         div_r <= 16'h0000;
      end else begin
         div_r <= div_r + 16'h0001;
      end
   end
   assign tick = (div_r == 16'(URXR_TICK_DIV - 1));

   always_ff @(posedge clk) begin
      if (reset) begin
         half_r <= 1'b0;
      end else if (tick) begin
         half_r <= ~half_r;
      end
   end
   // double speed halves the sample count per bit
   assign smp = tick && (~u2x_r || half_r);

   //----------------------------------------------------------
   // line sampling on ticks
   //----------------------------------------------------------
   always_ff @(posedge clk) begin
      if (reset) begin
         line_r <= 1'b1;
         prev_r <= 1'b1;
      end else if (smp) begin
         prev_r <= line_r;
         line_r <= serial_rx_pin;
      end
   end

   //----------------------------------------------------------
   // voter instance
   //----------------------------------------------------------
   assign vclr = ~rx_en || (smp && cnt_r == last_s) || state_r == URXR_IDLE;
   urxr_vote u_vote (
      .clk     (clk),
      .reset   (reset),
      .clr     (vclr),
      .smp     (smp),
      .num     (cnt_r + URXR_CNT_ONE),
      .first   (first_s),
      .line    (serial_rx_pin),
      .bit_val (vote)
   );

   //----------------------------------------------------------
   // clock and data recovery
   //----------------------------------------------------------
   always_ff @(posedge clk) begin
      if (reset || ~rx_en) begin
         state_r <= URXR_IDLE;
         cnt_r   <= URXR_CNT_ZERO;
         bit_r   <= URXR_BIT_ZERO;
         shf_r   <= 9'h000;
         par_r   <= 1'b0;
      end else if (smp) begin
         case (state_r)
            URXR_IDLE: begin
               // falling edge: this sample is number one
               if (line_r && ~serial_rx_pin) begin
                  state_r <= URXR_START;
                  cnt_r   <= URXR_CNT_ONE;
               end
            end
            URXR_START: begin
               cnt_r <= cnt_r + URXR_CNT_ONE;
               if ((cnt_r + URXR_CNT_ONE) == first_s + 4'h2) begin
                  // two or more high rejects as noise
                  if (vote) begin
                     state_r <= URXR_IDLE;
                  end
               end else if (cnt_r == last_s) begin
                  state_r <= URXR_DATA;
                  cnt_r   <= URXR_CNT_ZERO;
                  bit_r   <= URXR_BIT_ZERO;
               end
            end
            URXR_DATA: begin
               cnt_r <= (cnt_r == last_s) ? URXR_CNT_ZERO : cnt_r + URXR_CNT_ONE;
               if (vote_end) begin
                  if (bit_r < nbits) begin
                     shf_r[bit_r] <= vote;
                  end else if (pen && bit_r == nbits) begin
                     par_r <= vote;
                  end
                  if (bit_r == nbits + (pen ? 4'h1 : 4'h0)) begin
                     state_r <= URXR_IDLE;
                  end
                  bit_r <= bit_r + 4'h1;
               end
            end
            default: state_r <= URXR_IDLE;
         endcase
      end
   end

   // stop bit vote completes the frame
   assign push = rx_en && smp && state_r == URXR_DATA && vote_end
                 && bit_r == nbits + (pen ? 4'h1 : 4'h0);

   //----------------------------------------------------------
   // shifter holding, overrun detection
   //----------------------------------------------------------
   always_ff @(posedge clk) begin
      if (reset || ~rx_en) begin
         pend_r <= 1'b0;
         pfe_r  <= 1'b0;
         ppe_r  <= 1'b0;
         dor_r  <= 1'b0;
         pchk_r <= 1'b0;
      end else begin
         if (push) begin
            pend_r <= 1'b1;
            pfe_r  <= ~vote;
            pchk_r <= pen;
            ppe_r  <= pen && ((^(shf_r & ((9'h001 << nbits) - 9'h001)))
                      ^ par_r ^ ctrl_c_r[URXR_CC_PMLO]);
         end else if (pend_r && cnt_buf_r < 2'(URXR_DEPTH)) begin
            pend_r <= 1'b0;
            dor_r  <= 1'b0;
         end
         // buffer full, shifter full, new start: lose it
         if (pend_r && cnt_buf_r == 2'(URXR_DEPTH) && smp
             && state_r == URXR_IDLE && line_r && ~serial_rx_pin) begin
            dor_r  <= 1'b1;
            pend_r <= 1'b0;
         end
      end
   end

   //----------------------------------------------------------
   // two-entry receive buffer
   //----------------------------------------------------------
   assign rd_data = read && ack_r && address == URXR_ADDR_DATA;
   always_ff @(posedge clk) begin
      if (reset || ~rx_en) begin
         wp_r      <= 1'b0;
         rp_r      <= 1'b0;
         cnt_buf_r <= 2'b00;
      end else begin
         if (pend_r && cnt_buf_r < 2'(URXR_DEPTH) && ~push) begin
            // entry: {pe, dor, fe, ninth, data}
            mem_r[wp_r] <= {ppe_r & pchk_r, dor_r, pfe_r, shf_r};
            wp_r        <= ~wp_r;
         end
         if (rd_data && cnt_buf_r != 2'b00) begin
            rp_r <= ~rp_r;
         end
         cnt_buf_r <= cnt_buf_r
                    + 2'(pend_r && cnt_buf_r < 2'(URXR_DEPTH) && ~push)
                    - 2'(rd_data && cnt_buf_r != 2'b00);
      end
   end

   assign rx_complete_irq = ctrl_b_r[URXR_CB_RXCIE] && cnt_buf_r != 2'b00;

   //----------------------------------------------------------
   // registers written by software
   //----------------------------------------------------------
   always_ff @(posedge clk) begin
      if (reset) begin
         ctrl_b_r <= URXR_CTRL_B_RST;
         ctrl_c_r <= URXR_CTRL_C_RST;
         u2x_r    <= 1'b0;
      end else if (write && ack_r) begin
         case (address)
            // error bits cannot be written
            URXR_ADDR_STATUS: u2x_r <= writedata[URXR_ST_U2X];
            URXR_ADDR_CTRL_B: ctrl_b_r <= {writedata[7:2], 1'b0, writedata[0]};
            URXR_ADDR_CTRL_C: ctrl_c_r <= writedata[7:0];
            default: ;
         endcase
      end
   end

   //----------------------------------------------------------
   // bus answer: one wait cycle
   //----------------------------------------------------------
   always_ff @(posedge clk) begin
      if (reset || ack_r) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= read || write;
      end
   end
   assign waitrequest = (read || write) && ~ack_r;

   always_ff @(posedge clk) begin
      if (reset) begin
         readdata <= 32'h0000_0000;
      end else if (read && ~ack_r) begin
         case (address)
            // narrower sizes read upper bits as zero
            URXR_ADDR_DATA:   readdata <= {24'h00_0000,
                                 head[7:0] & ((8'h01 << nbits) - 8'h01) | {8{nbits > 4'h7}} & head[7:0]};
            URXR_ADDR_STATUS: readdata <= {24'h00_0000, cnt_buf_r != 2'b00, 2'b00,
                                 head[9] & (cnt_buf_r != 2'b00), head[10] & (cnt_buf_r != 2'b00),
                                 head[11] & (cnt_buf_r != 2'b00), u2x_r, 1'b0};
            URXR_ADDR_CTRL_B: readdata <= {24'h00_0000, ctrl_b_r[7:2],
                                 head[8] & (sz == URXR_SZ_NINE), ctrl_b_r[0]};
            URXR_ADDR_CTRL_C: readdata <= {24'h00_0000, ctrl_c_r};
            default:          readdata <= 32'h0000_0000;
         endcase
      end
   end

   //----------------------------------------------------------
   // checks
   //----------------------------------------------------------
   sequence s_data_read;
      rd_data && cnt_buf_r == 2'b01 && ~(pend_r && ~push);
   endsequence
   AST_FLUSH: assert property (@(posedge clk) disable iff (reset)
      $fell(rx_en) |=> cnt_buf_r == 2'b00 && state_r == URXR_IDLE)
      else $error("disable did not flush");
   AST_IRQ: assert property (@(posedge clk) disable iff (reset)
      ctrl_b_r[URXR_CB_RXCIE] && cnt_buf_r != 2'b00 |-> rx_complete_irq)
      else $error("irq missing with data held");
   AST_EMPTY: assert property (@(posedge clk) disable iff (reset)
      s_data_read |=> cnt_buf_r == 2'b00)
      else $error("read did not advance buffer");
   AST_OVR: assert property (@(posedge clk) disable iff (reset)
      rx_en && pend_r && cnt_buf_r == 2'(URXR_DEPTH) && smp && state_r == URXR_IDLE
      && line_r && ~serial_rx_pin |=> dor_r && ~pend_r)
      else $error("overrun not flagged");
   AST_START: assert property (@(posedge clk) disable iff (reset || ~rx_en)
      smp && state_r == URXR_IDLE && line_r && ~serial_rx_pin |=> state_r == URXR_START
      && cnt_r == URXR_CNT_ONE)
      else $error("start not detected");
   AST_PIN: assert property (@(posedge clk) disable iff (reset)
      ~rx_en |-> ~rx_pin_override)
      else $error("pin held while disabled");
   AST_PAR: assert property (@(posedge clk) disable iff (reset)
      push && ~pen |=> ~ppe_r)
      else $error("parity error with check off");
   AST_WAIT: assert property (@(posedge clk) disable iff (reset)
      (read || write) && ~ack_r |=> ack_r ##1 ~ack_r)
      else $error("bus answer not in one cycle");
endmodule

// [verification/urxr_line_tx.sv]
`timescale 1ns/10ps
// remote serial transmitter model, drives the receive line
module urxr_line_tx
   import urxr_pkg::*;
#(
   parameter int BIT_CLKS = 16 * URXR_TICK_DIV   // system clocks per bit
)
(
   input  wire logic clk,
   output logic      line
);
   //---------------------------------------------------------
   // line drive
   //---------------------------------------------------------
   // idle (mark) level before the first frame
   initial line = 1'b1;

   // hold a level for a number of system clocks
   task automatic hold(input logic v, input int clks);
      line <= v;
      repeat (clks) @(posedge clk);
   endtask

   // one frame: start, data lsb first, optional parity, one stop
   task automatic send(input logic [8:0] d, input int n, input logic par_on,
                       input logic par_odd, input logic par_flip, input logic stop_v);
      logic p;
      p = par_odd ^ par_flip;
      hold(1'b0, BIT_CLKS);
      for (int i = 0; i < n; i++) begin
         p = p ^ d[i];
         hold(d[i], BIT_CLKS);
      end
      if (par_on) begin
         hold(p, BIT_CLKS);
      end
      hold(stop_v, BIT_CLKS);
      // a low stop needs a mark so the next start has a falling edge
      if (!stop_v) begin
         hold(1'b1, BIT_CLKS);
      end
   endtask
endmodule

// [verification/test_urxr_top.sv]
`timescale 1ns/10ps
// self-checking bench for the receiver
module test_urxr_top;
   import urxr_pkg::*;
   localparam int BITC = 16 * URXR_TICK_DIV;   // clocks per bit
   logic        clk;
   logic        reset;
   logic [3:0]  address;
   logic        read;
   logic        write;
   logic [31:0] writedata;
   logic [31:0] readdata;
   logic        waitrequest;
   logic        rx_line;           // line from the model
   logic        rx_pin_override;
   logic        rx_complete_irq;
   int          fail_count;
   int          checked;
   logic [8:0]  d [4];             // frames sent

   urxr_top uut (.clk(clk), .reset(reset), .address(address), .read(read),
      .write(write), .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest), .serial_rx_pin(rx_line),
      .rx_pin_override(rx_pin_override), .rx_complete_irq(rx_complete_irq));
   urxr_line_tx tx (.clk(clk), .line(rx_line));

   // 50 MHz clock
   always #10 clk = ~clk;

   //---------------------------------------------------------
   // bus and compare tasks
   //---------------------------------------------------------
   task automatic bus_wr(input logic [3:0] a, input logic [7:0] wd);
      address <= a;
      writedata <= {24'h00_0000, wd};
      write <= 1'b1;
      // look at waitrequest between edges, the write lands at the next edge
      do @(negedge clk); while (waitrequest !== 1'b0);
      @(posedge clk);
      write <= 1'b0;
      @(posedge clk);
   endtask

   task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk_bit(input logic got, input logic exp);
      chk_reg({7'h00, got}, {7'h00, exp});
   endtask

   // read a register and compare its low byte
   task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
      logic [7:0] rd;
      address <= a;
      read <= 1'b1;
      // read data stand at the edge where waitrequest is sampled low
      do @(negedge clk); while (waitrequest !== 1'b0);
      @(posedge clk);
      rd = readdata[7:0];
      read <= 1'b0;
      @(posedge clk);
      chk_reg(rd, exp);
   endtask

   // control b with the received ninth bit folded in
   function automatic logic [7:0] cb(input logic [7:0] base, input logic b8);
      return base | {6'h00, b8, 1'b0};
   endfunction

   task automatic finish_test;
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   //---------------------------------------------------------
   // watchdog
   //---------------------------------------------------------
   initial begin
      repeat (90000) @(posedge clk);
      fail_count++;
      finish_test;
   end

   //---------------------------------------------------------
   // main sequence
   //---------------------------------------------------------
   initial begin
      clk = 1'b0;
      reset = 1'b1;
      address = 4'h0;
      read = 1'b0;
      write = 1'b0;
      writedata = 32'h0000_0000;
      fail_count = 0;
      checked = 0;
      void'($urandom(66475));
      repeat (12) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      // reset values, unmapped place, released pin
      rd_chk(URXR_ADDR_CTRL_B, URXR_CTRL_B_RST);
      rd_chk(URXR_ADDR_CTRL_C, URXR_CTRL_C_RST);
      rd_chk(URXR_ADDR_STATUS, 8'h00);
      bus_wr(4'h9, 8'hff);
      rd_chk(4'h9, 8'h00);
      chk_bit(rx_pin_override, 1'b0);
      // eight bits, even parity, preceded by a noise spike
      bus_wr(URXR_ADDR_CTRL_C, 8'h26);
      bus_wr(URXR_ADDR_CTRL_B, 8'h90);
      chk_bit(rx_pin_override, 1'b1);
      d[0] = 9'($urandom_range(255));
      tx.hold(1'b0, 5 * URXR_TICK_DIV);
      tx.hold(1'b1, 12 * URXR_TICK_DIV);
      tx.send(d[0], 8, 1'b1, 1'b0, 1'b0, 1'b1);
      chk_bit(rx_complete_irq, 1'b1);
      rd_chk(URXR_ADDR_STATUS, 8'h80);
      rd_chk(URXR_ADDR_DATA, d[0][7:0]);
      rd_chk(URXR_ADDR_STATUS, 8'h00);
      chk_bit(rx_complete_irq, 1'b0);
      // nine bits, odd parity: parity error, frame error, overrun
      bus_wr(URXR_ADDR_CTRL_C, 8'h36);
      bus_wr(URXR_ADDR_CTRL_B, 8'h94);
      for (int i = 0; i < 4; i++) begin
         d[i] = 9'($urandom_range(511));
         tx.send(d[i], 9, 1'b1, 1'b1, i == 0, i != 1);
      end
      rd_chk(URXR_ADDR_STATUS, 8'h84);
      bus_wr(URXR_ADDR_STATUS, 8'h18);
      rd_chk(URXR_ADDR_STATUS, 8'h84);
      rd_chk(URXR_ADDR_CTRL_B, cb(8'h94, d[0][8]));
      rd_chk(URXR_ADDR_DATA, d[0][7:0]);
      rd_chk(URXR_ADDR_STATUS, 8'h90);
      rd_chk(URXR_ADDR_CTRL_B, cb(8'h94, d[1][8]));
      rd_chk(URXR_ADDR_DATA, d[1][7:0]);
      rd_chk(URXR_ADDR_STATUS, 8'h88);
      rd_chk(URXR_ADDR_CTRL_B, cb(8'h94, d[3][8]));
      rd_chk(URXR_ADDR_DATA, d[3][7:0]);
      rd_chk(URXR_ADDR_STATUS, 8'h00);
      // double speed, five bits, interrupt disabled
      bus_wr(URXR_ADDR_CTRL_B, 8'h10);
      bus_wr(URXR_ADDR_CTRL_C, 8'h00);
      bus_wr(URXR_ADDR_STATUS, 8'h02);
      d[0] = 9'($urandom_range(511));
      tx.send(d[0], 5, 1'b0, 1'b0, 1'b0, 1'b1);
      chk_bit(rx_complete_irq, 1'b0);
      rd_chk(URXR_ADDR_STATUS, 8'h82);
      rd_chk(URXR_ADDR_DATA, {3'h0, d[0][4:0]});
      // buffered frame flushed by disable
      tx.send(~d[0], 5, 1'b0, 1'b0, 1'b0, 1'b1);
      rd_chk(URXR_ADDR_STATUS, 8'h82);
      bus_wr(URXR_ADDR_CTRL_B, 8'h00);
      rd_chk(URXR_ADDR_STATUS, 8'h02);
      chk_bit(rx_pin_override, 1'b0);
      // disable in mid-frame drops the reception
      bus_wr(URXR_ADDR_CTRL_B, 8'h10);
      fork
         tx.send(d[0], 5, 1'b0, 1'b0, 1'b0, 1'b1);
         begin
            repeat (2 * BITC) @(posedge clk);
            bus_wr(URXR_ADDR_CTRL_B, 8'h00);
         end
      join
      bus_wr(URXR_ADDR_CTRL_B, 8'h10);
      rd_chk(URXR_ADDR_STATUS, 8'h02);
      finish_test;
   end
endmodule
